//--- verilog/rmi_cfg.svh
`ifndef RMI_CFG_SVH
`define RMI_CFG_SVH

// message type codes on the indication port
`define RMI_T_ERR_COR      5'h00
`define RMI_T_ERR_FATAL    5'h02
`define RMI_T_INT_FIRST    5'h03
`define RMI_T_INT_LAST     5'h0a
`define RMI_T_PM_PME       5'h0b
`define RMI_T_PM_NAK       5'h0e
`define RMI_T_SLOT_PWR     5'h0f
`define RMI_T_LTR          5'h10
`define RMI_T_OBFF         5'h11
`define RMI_T_UNLOCK       5'h12
`define RMI_T_VDM0         5'h13
`define RMI_T_VDM1         5'h14
`define RMI_T_ATS_FIRST    5'h15
`define RMI_T_ATS_LAST     5'h18

// pulse lengths in cycles
`define RMI_LEN_SHORT      4'h2
`define RMI_LEN_OBFF       4'h3
`define RMI_LEN_VDM_NODATA 4'h4
`define RMI_LEN_SIX        4'h6
`define RMI_LEN_VDM_DATA   4'h8

// record layout in the fifo: type, flag, rid, w1, w2
`define RMI_REC_W          86
`define RMI_FIFO_DEPTH     32

`endif

//--- verilog/rmi_pkg.sv
package rmi_pkg;
   typedef enum logic {
      RMI_IDLE,
      RMI_SEND
   } rmi_state_e;

   typedef logic [4:0] rmi_type_t;
endpackage

//--- verilog/rmi_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module rmi_fifo #(
   parameter int WIDTH = 86,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } rmi_fifo_s;

   rmi_fifo_s        st_reg;
   rmi_fifo_s        st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;
   logic [AW:0]      used;

   // =====================================================
   // pointers and flags
   // extra pointer bit tells full from empty
   assign used      = st_reg.wr - st_reg.rd;
   assign in_ready  = (used != (AW+1)'(DEPTH));
   assign out_valid = (used != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[st_reg.rd[AW-1:0]];

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // storage has no reset; only the pointers matter
   always_ff @(posedge clk) begin
      if (push) begin
         mem[st_reg.wr[AW-1:0]] <= in_data;
      end
   end
endmodule
`default_nettype wire

//--- verilog/rmi_len.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmi_cfg.svh"
module rmi_len (
   // message classification
   input  wire logic [4:0] msg_type,
   input  wire logic       has_data,
   // result
   output logic      [3:0] pulse_len,
   output logic            known
);
   // pulse length per message type
   always_comb begin
      known = 1'b1;
      if (msg_type <= `RMI_T_PM_NAK) begin
         pulse_len = `RMI_LEN_SHORT;
      end else if (msg_type == `RMI_T_SLOT_PWR ||
                   msg_type == `RMI_T_LTR) begin
         pulse_len = `RMI_LEN_SIX;
      end else if (msg_type == `RMI_T_OBFF) begin
         pulse_len = `RMI_LEN_OBFF;
      end else if (msg_type == `RMI_T_UNLOCK) begin
         pulse_len = `RMI_LEN_SHORT;
      end else if (msg_type == `RMI_T_VDM0 ||
                   msg_type == `RMI_T_VDM1) begin
         pulse_len = has_data ? `RMI_LEN_VDM_DATA
                              : `RMI_LEN_VDM_NODATA;
      end else if (msg_type <= `RMI_T_ATS_LAST) begin
         pulse_len = `RMI_LEN_SHORT;
      end else begin
         // reserved codes are never announced
         pulse_len = `RMI_LEN_SHORT;
         known     = 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- verilog/rmi_msg_ind.sv
// Behaviour
// - when enabled, announce each link message of a known type with 5-bit type and valid.
// - while valid is high, one parameter byte per cycle.
// - vendor messages forward only the first payload dword.
// - codes 0-15: errors, INTx pairs, power management, slot power.
// - codes 16-24: LTR, OBFF, unlock, vendor, ATS; 25-31 reserved.
// - error, INTx, PM, unlock, ATS: two cycles of requester ID.
// - slot power: six cycles, ID then payload lowest byte first.
// - LTR: six cycles, ID, snoop latency, no-snoop latency.
// - OBFF: three cycles, ID then OBFF code.
// - vendor: four cycles without data, eight with, vendor ID first.
// - valid low at least one cycle between two pulses.
// - no flow-control input; indications never wait.
`timescale 1ns/100ps
`default_nettype none
`include "rmi_cfg.svh"
module rmi_msg_ind
   import rmi_pkg::*;
#(
   parameter int DEPTH = `RMI_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic           clk,
   input  wire logic           arst_n,
   // control
   input  wire logic           msg_if_enable,
   // decoded message from the link side
   input  wire logic           link_msg_valid,
   output logic                link_msg_ready,
   input  wire rmi_pkg::rmi_type_t link_msg_type,
   input  wire logic [15:0]    link_req_id,
   input  wire logic           link_has_data,
   input  wire logic [31:0]    link_word1,
   input  wire logic [31:0]    link_word2,
   // indication port to user logic
   output logic                ind_valid,
   output rmi_pkg::rmi_type_t  ind_type,
   output logic [7:0]          ind_data,
   output logic                msg_dropped
);
   import rmi_pkg::*;

   typedef struct packed {
      rmi_state_e state;
      logic [3:0] cnt;
      logic [3:0] len;
      logic [63:0] bytes;
      logic       gap;
      logic       valid;
      rmi_type_t  mtype;
      logic [7:0] data;
      logic       drop;
   } rmi_ind_s;

   rmi_ind_s                 st_reg;
   rmi_ind_s                 st_next;
   logic [`RMI_REC_W-1:0]    rec_in;
   logic [`RMI_REC_W-1:0]    rec_out;
   logic                     rec_valid;
   logic                     rec_pop;
   logic                     fifo_in_ready;
   logic [3:0]               rec_len;
   logic                     rec_known;
   logic                     accept;
   rmi_type_t                r_type;
   logic                     r_flag;
   logic [15:0]              r_rid;
   logic [31:0]              r_w1;
   logic [31:0]              r_w2;

   // =====================================================
   // intake: capture link messages into the fifo
   // only the first payload dword travels; longer vendor payloads
   // belong to the request path and are not seen here
   assign accept         = msg_if_enable && link_msg_valid;
   assign rec_in         = {link_msg_type, link_has_data, link_req_id,
                            link_word1, link_word2};
   assign link_msg_ready = fifo_in_ready;

   rmi_fifo #(
      .WIDTH (`RMI_REC_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (accept),
      .in_ready  (fifo_in_ready),
      .in_data   (rec_in),
      .out_valid (rec_valid),
      .out_ready (rec_pop),
      .out_data  (rec_out)
   );

   // =====================================================
   // record unpacking and length lookup
   assign {r_type, r_flag, r_rid, r_w1, r_w2} = rec_out;

   rmi_len u_len (
      .msg_type  (r_type),
      .has_data  (r_flag),
      .pulse_len (rec_len),
      .known     (rec_known)
   );

   // pop when idle and the mandatory gap is done
   assign rec_pop = (st_reg.state == RMI_IDLE) && !st_reg.gap;

   // =====================================================
   // byte sequencer
   // the user side has no ready, so the pulse never pauses
   always_comb begin
      st_next       = st_reg;
      st_next.drop  = 1'b0;
      st_next.gap   = 1'b0;
      case (st_reg.state)
         RMI_IDLE: begin
            st_next.valid = 1'b0;
            if (rec_valid && rec_pop) begin
               if (!rec_known) begin
                  // reserved code: discarded, flagged for one cycle
                  st_next.drop = 1'b1;
               end else begin
                  st_next.state = RMI_SEND;
                  st_next.valid = 1'b1;
                  st_next.mtype = r_type;
                  st_next.len   = rec_len;
                  st_next.cnt   = 4'h1;
                  st_next.data  = r_rid[15:8];
                  // bytes after the ID, lowest first
                  if (r_type == `RMI_T_LTR) begin
                     // snoop latency in the low half goes out first
                     st_next.bytes = {32'h0, r_w1[31:16],
                                      r_w1[15:0]};
                  end else if (r_type == `RMI_T_VDM0 ||
                               r_type == `RMI_T_VDM1) begin
                     st_next.bytes = {16'h0, r_w2, r_w1[15:0]};
                  end else begin
                     st_next.bytes = {32'h0, r_w1};
                  end
                  st_next.bytes = {st_next.bytes[55:0], r_rid[7:0]};
               end
            end
         end
         RMI_SEND: begin
            if (st_reg.cnt == st_reg.len) begin
               st_next.state = RMI_IDLE;
               st_next.valid = 1'b0;
               st_next.gap   = 1'b1;
               st_next.data  = 8'h00;
            end else begin
               st_next.cnt   = st_reg.cnt + 4'h1;
               st_next.data  = st_reg.bytes[7:0];
               st_next.bytes = {8'h00, st_reg.bytes[63:8]};
            end
         end
         default: begin
            st_next.state = RMI_IDLE;
            st_next.valid = 1'b0;
         end
      endcase
   end

   // state register; valid low during reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg       <= '0;
         st_reg.state <= RMI_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // =====================================================
   // outputs straight from the state register
   assign ind_valid   = st_reg.valid;
   assign ind_type    = st_reg.mtype;
   assign ind_data    = st_reg.data;
   assign msg_dropped = st_reg.drop;
endmodule
`default_nettype wire

//--- bench/rmi_props.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// indication port checker
module rmi_props
   import rmi_pkg::*;
(
   // clock and reset
   input wire logic               clk,
   input wire logic               arst_n,
   // indication port
   input wire logic               ind_valid,
   input wire rmi_pkg::rmi_type_t ind_type
);
   import rmi_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // pulse length per type family
   a_len_short: assert property (
      $rose(ind_valid) && ind_type inside {[0:14], 18, [21:24]}
      |-> ind_valid[*2] ##1 !ind_valid) else $error("short pulse length");
   a_len_six: assert property (
      $rose(ind_valid) && ind_type inside {15, 16}
      |-> ind_valid[*6] ##1 !ind_valid) else $error("six pulse length");
   a_len_obff: assert property (
      $rose(ind_valid) && ind_type == 17
      |-> ind_valid[*3] ##1 !ind_valid) else $error("obff pulse length");
   a_len_vendor: assert property (
      $rose(ind_valid) && ind_type inside {19, 20}
      |-> ind_valid[*4] ##1 (!ind_valid or ind_valid[*4] ##1 !ind_valid))
      else $error("vendor pulse length");
   // first dword only, so never past eight bytes
   a_len_max: assert property (
      ind_valid[*8] |=> !ind_valid) else $error("pulse too long");
   // designer fixed the gap at two low cycles
   a_gap_low: assert property (
      $fell(ind_valid) |=> !ind_valid) else $error("gap too short");
   a_type_hold: assert property (
      ind_valid && $past(ind_valid) |-> $stable(ind_type))
      else $error("type moved in pulse");
   a_no_rsvd: assert property (
      ind_valid |-> ind_type <= 5'h18) else $error("reserved code shown");
endmodule
bind rmi_msg_ind rmi_props i_props (.clk(clk), .arst_n(arst_n),
   .ind_valid(ind_valid), .ind_type(ind_type));
`default_nettype wire

//--- bench/rmi_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// user logic side, always ready
module rmi_rx_model
   import rmi_pkg::*;
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               arst_n,
   // indication port
   input  wire logic               ind_valid,
   input  wire rmi_pkg::rmi_type_t ind_type,
   input  wire logic [7:0]         ind_data,
   // last message taken
   output var logic [63:0]         got_bytes,
   output var logic [4:0]          got_type,
   output var logic [3:0]          got_len,
   output var int                  got_n
);
   import rmi_pkg::*;
   logic in_pulse;
   // a byte every valid cycle; no way to stall exists
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_pulse <= 1'b0;
         got_n <= 0;
      end else if (ind_valid) begin
         if (!in_pulse) begin
            got_bytes <= {56'h0, ind_data};
            got_len <= 4'h1;
            got_type <= ind_type;
         end else begin
            got_bytes[8*got_len +: 8] <= ind_data;
            got_len <= got_len + 4'h1;
         end
         in_pulse <= 1'b1;
      end else begin
         if (in_pulse)
            got_n <= got_n + 1;
         in_pulse <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import rmi_pkg::*;
   // ====================
   // signals
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        en = 1'b0;
   logic        lv = 1'b0;
   logic        lr, iv, dr, hd = 1'b0;
   rmi_type_t   lt = 5'h00, ity;
   logic [15:0] rid = 16'h0;
   logic [31:0] w1 = 32'h0, w2 = 32'h0;
   logic [7:0]  idt;
   logic [63:0] gb;
   logic [4:0]  gt;
   logic [3:0]  gl;
   int          gn, mismatches = 0, samples_checked = 0;
   int          cyc = 0, drops = 0, stalls = 0;
   always #12.5 clk = ~clk;
   rmi_msg_ind i_dut (.clk(clk), .arst_n(arst_n), .msg_if_enable(en),
      .link_msg_valid(lv), .link_msg_ready(lr), .link_msg_type(lt),
      .link_req_id(rid), .link_has_data(hd), .link_word1(w1),
      .link_word2(w2), .ind_valid(iv), .ind_type(ity), .ind_data(idt),
      .msg_dropped(dr));
   rmi_rx_model i_rx (.clk(clk), .arst_n(arst_n), .ind_valid(iv),
      .ind_type(ity), .ind_data(idt), .got_bytes(gb), .got_type(gt),
      .got_len(gl), .got_n(gn));
   // drop counter and hang guard; run needs about 650 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (dr === 1'b1)
         drops <= drops + 1;
      if (cyc == 20000) begin
         mismatches++;
         end_sim;
      end
   end
   // ====================
   // helpers
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function automatic logic [3:0] exp_len(input logic [4:0] t, input logic d);
      if (t == 5'h0f || t == 5'h10)
         return 4'h6;
      if (t == 5'h11)
         return 4'h3;
      if (t == 5'h13 || t == 5'h14)
         return d ? 4'h8 : 4'h4;
      return 4'h2;
   endfunction
   // request held from a falling edge up to the edge that takes it
   task automatic send(input logic [4:0] t, input logic d);
      @(negedge clk);
      lv = 1'b1;
      lt = t;
      hd = d;
      rid = {3'h5, t, ~t, 3'h2};
      w1 = 32'h87654321 ^ {4{3'h0, t}};
      w2 = ~w1;
      #2;
      while (lr !== 1'b1) begin
         stalls++;
         @(negedge clk);
         #2;
      end
      @(posedge clk);
   endtask
   task automatic one_msg(input logic [4:0] t, input logic d);
      int n;
      logic [63:0] b;
      logic [3:0] l;
      send(t, d);
      @(negedge clk);
      lv = 1'b0;
      n = gn;
      l = exp_len(t, d);
      b = (t > 5'h12) ? {w2, w1[15:0], rid[7:0], rid[15:8]}
                      : {16'h0, w1, rid[7:0], rid[15:8]};
      for (int i = 0; i < 40 && gn == n; i++)
         @(negedge clk);
      chk(gn, n + 1);
      chk(gt, t);
      chk(gl, l);
      chk(gb, b & ((64'h1 << (8 * l)) - 64'h1));
   endtask
   // ====================
   // scenarios
   task automatic t_codes;
      for (int t = 0; t < 25; t++)
         one_msg(t[4:0], t[0]);
   endtask
   task automatic t_reserved;
      int n = gn;
      int d0 = drops;
      for (int t = 25; t < 32; t++)
         send(t[4:0], 1'b0);
      @(negedge clk);
      lv = 1'b0;
      repeat (30) @(negedge clk);
      chk(gn, n);
      chk(drops, d0 + 7);
   endtask
   task automatic t_disabled;
      int n = gn;
      en = 1'b0;
      send(5'h00, 1'b0);
      @(negedge clk);
      lv = 1'b0;
      repeat (20) @(negedge clk);
      chk(gn, n);
      en = 1'b1;
   endtask
   // fill the buffer until it refuses, user side never stalls
   task automatic t_burst;
      int n = gn;
      stalls = 0;
      for (int i = 0; i < 48; i++)
         send(5'h10, 1'b0);
      @(negedge clk);
      lv = 1'b0;
      for (int i = 0; i < 1000 && gn != n + 48; i++)
         @(negedge clk);
      chk(gn, n + 48);
      chk(stalls > 0, 1);
   endtask
   // reset in mid-pulse drops valid at once; traffic resumes after
   task automatic t_reset;
      send(5'h0f, 1'b0);
      @(negedge clk);
      lv = 1'b0;
      for (int i = 0; i < 10 && iv !== 1'b1; i++)
         @(negedge clk);
      arst_n = 1'b0;
      #1;
      chk(iv, 1'b0);
      @(negedge clk);
      chk(iv, 1'b0);
      arst_n = 1'b1;
      one_msg(5'h11, 1'b0);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      en = 1'b1;
      t_codes();
      t_reserved();
      t_disabled();
      t_burst();
      t_reset();
      end_sim;
   end
endmodule
`default_nettype wire
